// File: csc_clock_ctrl.sv
// clock select, strap latch and clock stop control
`timescale 1ns/1ps

// Overview of operation
// (R1) latched mode strap picks pin 3: 0 pci halt input, 1 ref output.
// (R2) pci divide: 11xx by four, 10xx/01xx by three, 0011-0001 by two, 0000 by three.
// (R3) each select code maps to a cpu target frequency.
// (R4) select code comes from latched straps or a software-written value.
// (R5) both stoppable cpu outputs are gated by the clock halt input.
// (R6) free-running cpu output keeps toggling whatever the halt input.
// (R7) pci outputs zero to five are gated by the pci halt input.
// (R8) free-running pci output keeps toggling whatever the pci halt input.
// (R9) halt falling: finish current full cycle, then hold stoppable outputs low.
// (R10) halt rising: stoppable outputs restart with a complete cycle.
// (R11) gated apic output carries the reference, off while halt is low.
// (R12) free apic output buffers the reference, never gated.
// (R13) select bit one latched from the 48 MHz pin, which then drives it.
// (R14) select bit zero latched from the 24 MHz pin, which then drives it.
// (R15) select bit three defaults to zero when its pin is left unstrapped.
// (R16) pci halt sampled on free pci rise, applied from the next cycle.
// (R17) dual pins three-stated 2 ms, then latched, then enabled as outputs.
// (R18) select bit two latched from the second reference output pin.
// (R19) latched straps cleared only by power removal and reapply.
// (R20) halt inputs resynchronised so no truncated pulses appear.
module csc_clock_ctrl
	import csc_pkg::*;
#(
	parameter int STRAP_WAIT_CYCLES = STRAP_WAIT_CYC
)(
	// clock and power-on reset
	input  wire logic              clk_sys_in,
	input  wire logic              reset_n_in,
	// avalon-mm slave
	input  wire logic [3:0]        av_address_in,
	input  wire logic              av_read_in,
	input  wire logic              av_write_in,
	input  wire logic [31:0]       av_writedata_in,
	input  wire logic [3:0]        av_byteenable_in,
	output logic      [31:0]       av_readdata_out,
	output logic                   av_waitrequest_out,
	// dual-purpose strap/clock pins
	input  wire logic [DP_N-1:0]   dual_pin_in,
	output logic      [DP_N-1:0]   dual_pin_out,
	output logic      [DP_N-1:0]   dual_pin_oe_out,
	// pin 3: pci halt input or ref output
	input  wire logic              pin3_in,
	output logic                   pin3_out,
	output logic                   pin3_oe_out,
	// halt and reference inputs
	input  wire logic              clk_halt_n_in,
	input  wire logic              ref_clk_in,
	// clock outputs
	output logic                   cpu_free_clk_out,
	output logic      [1:0]        cpu_gated_clk_out,
	output logic      [4:0]        pci_gated_clk_out,
	output logic                   apic_free_clk_out,
	output logic                   apic_gated_clk_out,
	// status
	output csc_freq_s              freq_out,
	output csc_strap_s             strap_out
);

	localparam int WAIT_W = $clog2(STRAP_WAIT_CYCLES + 1);

	// ==========================================================
	// reset release
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ==========================================================
	// input synchronisers
	logic [SY_N-1:0] sy_raw;
	logic [SY_N-1:0] sy_s1;
	logic [SY_N-1:0] sy_s2;
	logic [SY_N-1:0] sy_s3;
	logic [SY_N-1:0] sy_val;

	assign sy_raw = {ref_clk_in, clk_halt_n_in, pin3_in,
		dual_pin_in[DP_PCIF], dual_pin_in[DP_PCI_GATED_CLK_ZERO],
		dual_pin_in[DP_REF_CLK_OUT_ONE], dual_pin_in[DP_USB], dual_pin_in[DP_SIO]};

	generate
		for (genvar i = 0; i < SY_N; i++)
		begin : g_sync
			always_ff @(posedge clk_sys_in or negedge rst_n)
			begin
				if (!rst_n)
				begin
					sy_s1[i]  <= 1'b0;
					sy_s2[i]  <= 1'b0;
					sy_s3[i]  <= 1'b0;
					sy_val[i] <= 1'b0;
				end
				else
				begin
					sy_s1[i] <= sy_raw[i];
					sy_s2[i] <= sy_s1[i];
					sy_s3[i] <= sy_s2[i];
					if (sy_s2[i] == sy_s3[i])
						sy_val[i] <= sy_s3[i]; // R20
				end
			end
		end
	endgenerate

	// ==========================================================
	// strap wait and latch
	logic [WAIT_W-1:0] wait_cnt;
	logic              latched;
	csc_strap_s        straps;

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_cnt <= '0;
			latched  <= 1'b0;
			straps   <= '0;
		end
		else if (!latched) // R19
		begin
			if (wait_cnt == WAIT_W'(STRAP_WAIT_CYCLES - 1))
			begin
				latched    <= 1'b1; // R17
				straps.fs  <= sy_val[SY_FS3:SY_FS0]; // R13 R14 R15 R18
				straps.mode <= sy_val[SY_MODE]; // R1
			end
			else
				wait_cnt <= wait_cnt + WAIT_W'(1);
		end
	end

	// ==========================================================
	// avalon slave and select register
	logic       prog_en;
	logic [3:0] prog_code;
	logic       av_req;
	logic       av_done;
	logic [3:0] sel_code;

	assign av_req   = av_read_in | av_write_in;
	assign av_done  = av_req & ~av_waitrequest_out;
	assign sel_code = prog_en ? prog_code : straps.fs; // R4

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			av_waitrequest_out <= 1'b1;
		else
			av_waitrequest_out <= ~(av_req & av_waitrequest_out);
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prog_en   <= 1'b0;
			prog_code <= 4'h0;
		end
		else if (av_done && av_write_in && av_byteenable_in[0]
			&& av_address_in == REG_PROG)
		begin
			prog_en   <= av_writedata_in[PROG_EN_BIT];
			prog_code <= av_writedata_in[PROG_CODE_LSB +: 4];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			av_readdata_out <= RESET_WORD;
		else if (av_read_in && av_waitrequest_out)
		begin
			av_readdata_out <= RESET_WORD;
			if (av_address_in == REG_PROG)
			begin
				av_readdata_out[PROG_EN_BIT]           <= prog_en;
				av_readdata_out[PROG_CODE_LSB +: 4]    <= prog_code;
			end
			else if (av_address_in == REG_STATUS)
			begin
				av_readdata_out[ST_FS_LSB +: 4]  <= straps.fs;
				av_readdata_out[ST_MODE_BIT]     <= straps.mode;
				av_readdata_out[ST_LATCH_BIT]    <= latched;
				av_readdata_out[ST_DIV_LSB +: 3] <= freq_out.pci_div;
				av_readdata_out[ST_TGT_LSB +: 11] <= freq_out.cpu_target;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			freq_out <= '0;
		else
		begin
			freq_out.cpu_target <= CPU_TARGET_TBL[sel_code]; // R3
			freq_out.pci_div    <= csc_pci_div(sel_code); // R2
		end
	end

	// ==========================================================
	// cpu and pci clock generation with stop control
	logic [HALF_CNT_W-1:0] cpu_cnt;
	logic                  cpu_tick;
	logic                  cpu_lvl;
	logic                  cpu_run;
	logic                  cpu_gated;
	logic [HALF_CNT_W-1:0] pci_cnt;
	logic                  pci_lvl;
	logic                  pci_run;
	logic                  pci_gated;
	logic                  pci_halt_ok;

	assign cpu_tick    = cpu_cnt == HALF_CNT_W'(CPU_HALF_CYC - 1);
	assign pci_halt_ok = straps.mode | sy_val[SY_PIN3]; // R1

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_cnt   <= '0;
			cpu_lvl   <= 1'b0;
			cpu_run   <= 1'b0;
			cpu_gated <= 1'b0;
		end
		else
		begin
			cpu_cnt <= cpu_tick ? '0 : cpu_cnt + HALF_CNT_W'(1);
			if (cpu_tick)
			begin
				cpu_lvl   <= ~cpu_lvl; // R6
				cpu_gated <= ~cpu_lvl & cpu_run; // R5 R10
				if (cpu_lvl)
					cpu_run <= sy_val[SY_HALT]; // R9 R20
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pci_cnt   <= '0;
			pci_lvl   <= 1'b0;
			pci_run   <= 1'b0;
			pci_gated <= 1'b0;
		end
		else if (cpu_tick)
		begin
			if (pci_cnt >= HALF_CNT_W'(freq_out.pci_div - 3'h1))
			begin
				pci_cnt   <= '0;
				pci_lvl   <= ~pci_lvl; // R8
				pci_gated <= ~pci_lvl & pci_run; // R7
				if (!pci_lvl)
					pci_run <= pci_halt_ok; // R16 R20
			end
			else
				pci_cnt <= pci_cnt + HALF_CNT_W'(1);
		end
	end

	// ==========================================================
	// reference, apic and usb/sio clocks
	logic [HALF_CNT_W-1:0] usb_cnt;
	logic                  usb_lvl;
	logic                  sio_lvl;
	logic                  apic_run;

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			usb_cnt <= '0;
			usb_lvl <= 1'b0;
			sio_lvl <= 1'b0;
		end
		else if (usb_cnt == HALF_CNT_W'(USB_HALF_CYC - 1))
		begin
			usb_cnt <= '0;
			usb_lvl <= ~usb_lvl;
			if (!usb_lvl)
				sio_lvl <= ~sio_lvl;
		end
		else
			usb_cnt <= usb_cnt + HALF_CNT_W'(1);
	end

	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
			apic_run <= 1'b0;
		else if (!sy_val[SY_REF])
			apic_run <= sy_val[SY_HALT]; // R11 R20
	end

	// ==========================================================
	// registered output stage
	always_ff @(posedge clk_sys_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_free_clk_out   <= 1'b0;
			cpu_gated_clk_out  <= '0;
			pci_gated_clk_out  <= '0;
			apic_free_clk_out  <= 1'b0;
			apic_gated_clk_out <= 1'b0;
			dual_pin_out       <= '0;
			dual_pin_oe_out    <= '0;
			pin3_out           <= 1'b0;
			pin3_oe_out        <= 1'b0;
			strap_out          <= '0;
		end
		else
		begin
			cpu_free_clk_out   <= cpu_lvl; // R6
			cpu_gated_clk_out  <= {2{cpu_gated}}; // R5
			pci_gated_clk_out  <= {5{pci_gated}}; // R7
			apic_free_clk_out  <= sy_val[SY_REF]; // R12
			apic_gated_clk_out <= sy_val[SY_REF] & apic_run; // R11
			dual_pin_out[DP_SIO]  <= sio_lvl; // R14
			dual_pin_out[DP_USB]  <= usb_lvl; // R13
			dual_pin_out[DP_REF_CLK_OUT_ONE] <= sy_val[SY_REF]; // R18
			dual_pin_out[DP_PCI_GATED_CLK_ZERO] <= pci_gated; // R7
			dual_pin_out[DP_PCIF] <= pci_lvl; // R8
			dual_pin_oe_out    <= {DP_N{latched}}; // R17
			pin3_out           <= sy_val[SY_REF];
			pin3_oe_out        <= latched & straps.mode; // R1
			strap_out          <= straps;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n);

	sequence s_cpu_high_full;
		cpu_gated_clk_out[0] [*2];
	endsequence

	property p_pins_hidden;
		!latched |=> dual_pin_oe_out == '0;
	endproperty
	a_pins_hidden: assert property (p_pins_hidden) // R17
		else $error("dual pins driven before strap latch");

	property p_straps_hold;
		latched |=> latched && $stable(straps);
	endproperty
	a_straps_hold: assert property (p_straps_hold) // R19
		else $error("latched straps changed");

	property p_pin3_role;
		latched |=> pin3_oe_out == straps.mode;
	endproperty
	a_pin3_role: assert property (p_pin3_role) // R1
		else $error("pin 3 role does not follow mode strap");

	property p_pci_div;
		latched && !prog_en |=> freq_out.pci_div == csc_pci_div(straps.fs);
	endproperty
	a_pci_div: assert property (p_pci_div) // R2
		else $error("pci divide does not match select code");

	property p_prog_target;
		prog_en |=> freq_out.cpu_target == CPU_TARGET_TBL[$past(prog_code)];
	endproperty
	a_prog_target: assert property (p_prog_target) // R4
		else $error("programmed code not applied");

	property p_cpu_stop;
		$rose(cpu_gated_clk_out[0]) |-> $past(cpu_run, 2);
	endproperty
	a_cpu_stop: assert property (p_cpu_stop) // R5
		else $error("stopped cpu output rose");

	property p_cpu_full;
		$rose(cpu_gated_clk_out[0]) |-> s_cpu_high_full;
	endproperty
	a_cpu_full: assert property (p_cpu_full) // R10
		else $error("cpu output restart pulse truncated");

	// skip attempts that start before the dividers have left reset
	property p_cpu_free;
		$past(rst_n, 2) |-> ##[1:2] $changed(cpu_free_clk_out);
	endproperty
	a_cpu_free: assert property (p_cpu_free) // R6
		else $error("free cpu output stalled");

	property p_pci_free;
		$past(rst_n, 2) |-> ##[1:8] $changed(dual_pin_out[DP_PCIF]);
	endproperty
	a_pci_free: assert property (p_pci_free) // R8
		else $error("free pci output stalled");

	property p_pci_stop;
		$rose(pci_gated_clk_out[0]) |-> $past(pci_run, 2);
	endproperty
	a_pci_stop: assert property (p_pci_stop) // R7
		else $error("stopped pci output rose");

	property p_apic_gate;
		apic_gated_clk_out |-> $past(apic_run);
	endproperty
	a_apic_gate: assert property (p_apic_gate) // R11
		else $error("gated apic output high while stopped");

endmodule : csc_clock_ctrl

// File: csc_pkg.sv
// constants, types and lookup tables for the clock select and stop control
package csc_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS   = 20;
	localparam int STRAP_WAIT_NS   = 2_000_000;
	localparam int STRAP_WAIT_CYC  = (STRAP_WAIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CPU_HALF_CYC    = 2;
	localparam int USB_HALF_CYC    = 1;
	localparam int HALF_CNT_W      = 4;

	// ==========================================================
	// synchroniser bit positions
	localparam int SY_FS0  = 0;
	localparam int SY_FS1  = 1;
	localparam int SY_FS2  = 2;
	localparam int SY_FS3  = 3;
	localparam int SY_MODE = 4;
	localparam int SY_PIN3 = 5;
	localparam int SY_HALT = 6;
	localparam int SY_REF  = 7;
	localparam int SY_N    = 8;

	// dual-purpose pin positions
	localparam int DP_SIO  = 0;
	localparam int DP_USB  = 1;
	localparam int DP_REF_CLK_OUT_ONE = 2;
	localparam int DP_PCI_GATED_CLK_ZERO = 3;
	localparam int DP_PCIF = 4;
	localparam int DP_N    = 5;

	// ==========================================================
	// register map, byte addresses
	localparam logic [3:0] REG_PROG   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int PROG_CODE_LSB = 0;
	localparam int PROG_EN_BIT   = 4;
	localparam int ST_FS_LSB     = 0;
	localparam int ST_MODE_BIT   = 4;
	localparam int ST_LATCH_BIT  = 5;
	localparam int ST_DIV_LSB    = 8;
	localparam int ST_TGT_LSB    = 16;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ==========================================================
	// types
	typedef struct packed {
		logic       mode;
		logic [3:0] fs;
	} csc_strap_s;

	typedef struct packed {
		logic [10:0] cpu_target;
		logic [2:0]  pci_div;
	} csc_freq_s;

	// cpu target in units of 0.1 MHz, indexed by select code
	localparam logic [15:0][10:0] CPU_TARGET_TBL = {
		11'h535, 11'h4D8, 11'h5DC, 11'h578,
		11'h41A, 11'h44C, 11'h47E, 11'h4B0,
		11'h3E8, 11'h535, 11'h460, 11'h406,
		11'h29C, 11'h341, 11'h2EE, 11'h4D8
	};

	function automatic logic [2:0] csc_pci_div(input logic [3:0] code);
		logic [2:0] d;
		d = 3'h3;
		if (code[3:2] == 2'b11)
			d = 3'h4;
		else if (code[3] ^ code[2])
			d = 3'h3;
		else if (code != 4'h0)
			d = 3'h2;
		return d;
	endfunction : csc_pci_div

endpackage : csc_pkg

// File: csc_board_model.sv
// board model: strap resistors, pci halt driver, crystal reference
`timescale 1ns/1ps
module csc_board_model
	import csc_pkg::*;
(
	// device side
	input  wire logic [DP_N-1:0] dev_pin_in,
	input  wire logic [DP_N-1:0] dev_oe_in,
	input  wire logic            dev_p3_in,
	input  wire logic            dev_p3_oe_in,
	output logic      [DP_N-1:0] pin_level_out,
	output logic                 p3_level_out,
	output logic                 ref_clk_out,
	// board settings
	input  wire logic [DP_N-1:0] strap_in,
	input  wire logic            fs3_fitted_in,
	input  wire logic            pci_halt_n_in
);
	logic [DP_N-1:0] level;

	// ==========================================================
	// strap resistors, pci_gated_clk_zero pad pulled down when none fitted
	always_comb
	begin
		level = strap_in;
		if (!fs3_fitted_in)
			level[DP_PCI_GATED_CLK_ZERO] = 1'b0;
	end

	// device drive wins once enabled
	assign pin_level_out = (dev_oe_in & dev_pin_in)
		| (~dev_oe_in & level);
	assign p3_level_out = dev_p3_oe_in ? dev_p3_in : pci_halt_n_in;

	// ==========================================================
	// crystal reference, unrelated in phase
	initial ref_clk_out = 1'b0;
	always #35 ref_clk_out = ~ref_clk_out;
endmodule : csc_board_model

// File: test_clock_select_and_stop_control.sv
// self-checking testbench for the clock select and stop control
`timescale 1ns/1ps
module test_clock_select_and_stop_control
	import csc_pkg::*;
;
	logic              clk_sys_in = 1'b0;
	logic              reset_n_in = 1'b0;
	logic [3:0]        av_address = 4'h0;
	logic              av_read = 1'b0;
	logic              av_write = 1'b0;
	logic [31:0]       av_wdata = 32'h0000_0000;
	logic [3:0]        av_be = 4'h0;
	logic [31:0]       av_rdata;
	logic              av_wait;
	logic [DP_N-1:0]   dual_in, dual_out, dual_oe;
	logic              pin3_in, pin3_out, pin3_oe;
	logic              clk_halt_n = 1'b1;
	logic              ref_clk;
	logic              cpu_free, apic_f, apic_g;
	logic [1:0]        cpu_g;
	logic [4:0]        pci_g;
	csc_freq_s         freq;
	csc_strap_s        strap;
	logic [DP_N-1:0]   strap_pins = 5'h00;
	logic              fs3_fit = 1'b0;
	logic              pci_halt_n = 1'b1;
	logic [31:0]       q;
	int                n_mismatch = 0;
	int                checked = 0;
	int                cnt [12];
	int                tgt [16] = '{1240, 750, 833, 668, 1030, 1120, 1333,
		1000, 1200, 1150, 1100, 1050, 1400, 1500, 1240, 1333};

	always #10 clk_sys_in = ~clk_sys_in;

	csc_clock_ctrl #(.STRAP_WAIT_CYCLES(20)) i_dut (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.av_address_in(av_address), .av_read_in(av_read),
		.av_write_in(av_write), .av_writedata_in(av_wdata),
		.av_byteenable_in(av_be), .av_readdata_out(av_rdata),
		.av_waitrequest_out(av_wait), .dual_pin_in(dual_in),
		.dual_pin_out(dual_out), .dual_pin_oe_out(dual_oe),
		.pin3_in(pin3_in), .pin3_out(pin3_out), .pin3_oe_out(pin3_oe),
		.clk_halt_n_in(clk_halt_n), .ref_clk_in(ref_clk),
		.cpu_free_clk_out(cpu_free), .cpu_gated_clk_out(cpu_g),
		.pci_gated_clk_out(pci_g), .apic_free_clk_out(apic_f),
		.apic_gated_clk_out(apic_g), .freq_out(freq), .strap_out(strap));

	csc_board_model i_board (
		.dev_pin_in(dual_out), .dev_oe_in(dual_oe), .dev_p3_in(pin3_out),
		.dev_p3_oe_in(pin3_oe), .pin_level_out(dual_in),
		.p3_level_out(pin3_in), .ref_clk_out(ref_clk),
		.strap_in(strap_pins), .fs3_fitted_in(fs3_fit),
		.pci_halt_n_in(pci_halt_n));

	// ==========================================================
	// checking helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [2:0] exp_div(input logic [3:0] c);
		if (c[3] && c[2])
			return 3'h4;
		if (c[3] || c[2] || c == 4'h0)
			return 3'h3;
		return 3'h2;
	endfunction : exp_div

	// rising edges of every clock output over n cycles
	task automatic watch(input int n);
		logic [11:0] v, p;
		cnt = '{default: 0};
		p = 12'hfff;
		repeat (n)
		begin
			@(posedge clk_sys_in);
			v = {pin3_out, dual_out[DP_REF_CLK_OUT_ONE], dual_out[DP_SIO],
				dual_out[DP_USB], apic_g, apic_f, dual_out[DP_PCIF],
				dual_out[DP_PCI_GATED_CLK_ZERO], pci_g[0], cpu_g, cpu_free};
			for (int i = 0; i < 12; i++)
				if (v[i] && !p[i])
					cnt[i]++;
			chk({31'h0, pci_g == 5'h00 || pci_g == 5'h1f}, 32'h1);
			p = v;
		end
	endtask : watch

	task automatic runs(input logic [11:0] exp, input logic [11:0] care);
		for (int i = 0; i < 12; i++)
			if (care[i])
				chk({31'h0, cnt[i] > 0}, {31'h0, exp[i]});
	endtask : runs

	// ==========================================================
	// avalon master: hold until waitrequest low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		av_address <= a;
		av_wdata <= d;
		av_be <= be;
		av_write <= wr;
		av_read <= !wr;
		@(posedge clk_sys_in);
		while (av_wait !== 1'b0 && n < 20)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		q = av_rdata;
		av_write <= 1'b0;
		av_read <= 1'b0;
		chk({31'h0, n < 20}, 32'h1);
	endtask : bus

	// power cycle with given straps, then wait for pins to turn
	task automatic power_up(input logic [4:0] s, input logic fit);
		int n;
		reset_n_in <= 1'b0;
		strap_pins <= s;
		fs3_fit <= fit;
		repeat (5) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		repeat (5) @(posedge clk_sys_in);
		n = 5;
		chk({27'h0, dual_oe}, 32'h0);
		while (dual_oe !== 5'h1f && n < 60)
		begin
			@(posedge clk_sys_in);
			n++;
		end
		chk({31'h0, n >= 20 && n < 60}, 32'h1);
		repeat (4) @(posedge clk_sys_in);
	endtask : power_up

	task automatic results;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	initial
	begin
		repeat (6000) @(posedge clk_sys_in);
		n_mismatch++;
		results();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		// mode 0, code 0011, pci_gated_clk_zero strap unfitted
		power_up(5'b01011, 1'b0);
		chk({27'h0, strap}, 32'h03);
		chk({31'h0, pin3_oe}, 32'h0);
		chk({18'h0, freq}, {18'h0, 11'd668, 3'h2});
		watch(40);
		runs(12'h7ff, 12'h7ff);
		clk_halt_n <= 1'b0;
		repeat (20) @(posedge clk_sys_in);
		watch(40);
		runs(12'h779, 12'h7ff);
		chk({30'h0, cpu_g}, 32'h0);
		clk_halt_n <= 1'b1;
		repeat (20) @(posedge clk_sys_in);
		watch(40);
		runs(12'h0ff, 12'h0ff);
		pci_halt_n <= 1'b0;
		repeat (40) @(posedge clk_sys_in);
		watch(60);
		runs(12'h0e7, 12'h0ff);
		pci_halt_n <= 1'b1;
		repeat (40) @(posedge clk_sys_in);
		watch(60);
		runs(12'h0ff, 12'h0ff);
		for (int c = 0; c < 16; c++)
		begin
			bus(1'b1, REG_PROG, 32'h10 | c, 4'hf);
			bus(1'b0, REG_STATUS, 32'h0, 4'hf);
			chk(q & 32'h07ff_073f, {5'h0, 11'(tgt[c]), 5'h0,
				exp_div(4'(c)), 8'h23});
			chk({18'h0, freq}, {18'h0, 11'(tgt[c]),
				exp_div(4'(c))});
		end
		bus(1'b1, REG_PROG, 32'h1d, 4'he);
		repeat (3) @(posedge clk_sys_in);
		chk({18'h0, freq}, {18'h0, 11'd1333, 3'h4});
		bus(1'b1, REG_PROG, 32'h0d, 4'hf);
		repeat (3) @(posedge clk_sys_in);
		chk({18'h0, freq}, {18'h0, 11'd668, 3'h2});
		bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
		bus(1'b0, 4'h8, 32'h0, 4'hf);
		chk(q, 32'h0000_0000);
		// mode 1, code 1101, pci_gated_clk_zero strap fitted
		power_up(5'b11101, 1'b1);
		chk({27'h0, strap}, 32'h1d);
		chk({31'h0, pin3_oe}, 32'h1);
		chk({18'h0, freq}, {18'h0, 11'd1500, 3'h4});
		pci_halt_n <= 1'b0;
		repeat (40) @(posedge clk_sys_in);
		watch(60);
		runs(12'hfff, 12'hfff);
		results();
	end
endmodule : test_clock_select_and_stop_control
